// [crystal_clocked_watchdog_pkg.sv]
// constants for the crystal clocked watchdog: register place, field layout, reset value, timing
// assumes an 8-bit special-function register port and a free running crystal of about 32 kHz
package crystal_clocked_watchdog_pkg;
    // register place and power-on value
    localparam logic [7:0] WATCHDOG_CONTROL_ADDR  = 8'hC0;
    localparam logic [7:0] WATCHDOG_CONTROL_RESET = 8'h10;
    // bit positions inside watchdog_control
    localparam int UNLOCK_POS   = 0;
    localparam int ENABLE_POS   = 1;
    localparam int STATUS_POS   = 2;
    localparam int IRQ_SEL_POS  = 3;
    localparam int PRESCALE_LSB = 4;
    localparam int PRESCALE_MSB = 7;
    // prescale codes with special meaning
    localparam logic [3:0] PRESCALE_MAX_TIMED = 4'h7;
    localparam logic [3:0] PRESCALE_IMMEDIATE = 4'h8;
    // crystal figures; timeout is 2^(BASE_SHIFT + code) crystal periods
    localparam int CRYSTAL_HZ    = 32768;
    localparam int BASE_SHIFT    = 9;
    localparam int COUNT_WIDTH   = BASE_SHIFT + 8;
    localparam int BASE_PERIOD_US = (1000000 << BASE_SHIFT) / CRYSTAL_HZ; // 15625 us at code 0
    // core clock
    localparam int CLK_HZ        = 10000000;
    // three-stage pin synchroniser length
    localparam int SYNC_STAGES   = 3;
endpackage

// [crystal_tick_if.sv]
// carrier between the crystal sampler and the watchdog core
// assumes both ends run on the same core clock
`timescale 1ns/100ps
interface crystal_tick_if;
    logic tickPulse;   // one core cycle per crystal rising edge
    logic xtalLevel;   // filtered crystal level
    modport sampler (output tickPulse, output xtalLevel);
    modport core    (input  tickPulse, input  xtalLevel);
endinterface // crystal_tick_if

// [crystal_tick_sampler.sv]
// samples the crystal pin on the core clock and marks each rising edge
// assumes the crystal is much slower than the core clock
`timescale 1ns/100ps
module crystal_tick_sampler
    import crystal_clocked_watchdog_pkg::*;
(
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rst_n,
    input  wire logic   ce,
    // crystal pin
    input  wire logic   crystalInPin,
    // to core
    crystal_tick_if.sampler tick
);
    logic [SYNC_STAGES-1:0] sync_reg;
    logic                   level_reg;
    logic                   pulse_reg;

    // three flops; a change counts once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_reg  <= '0;
            level_reg <= 1'b0;
            pulse_reg <= 1'b0;
        end else if (ce) begin
            sync_reg  <= {sync_reg[SYNC_STAGES-2:0], crystalInPin};
            pulse_reg <= 1'b0;
            if (sync_reg[1] == sync_reg[2] && sync_reg[2] != level_reg) begin
                level_reg <= sync_reg[2];
                pulse_reg <= sync_reg[2]; // rising edge only
            end
        end
    end

    assign tick.tickPulse = pulse_reg;
    assign tick.xtalLevel = level_reg;
endmodule // crystal_tick_sampler

// [crystal_clocked_watchdog.sv]
// watchdog supervisor with its control register on the special-function port
// assumes rst_n is the power-on or external hardware reset; a watchdog reset is requested on wdtResetReq
`timescale 1ns/100ps
module crystal_clocked_watchdog
    import crystal_clocked_watchdog_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // special-function byte port
    input  wire logic [7:0] sfrAddr,
    input  wire logic       sfrWr,
    input  wire logic [7:0] sfrWrData,
    output logic      [7:0] sfrRdData,
    // special-function bit port
    input  wire logic [7:0] bitAddr,
    input  wire logic       bitWr,
    input  wire logic       bitVal,
    // crystal pins
    input  wire logic       crystalInPin,
    output logic            crystalOutPin,
    // watchdog actions
    output logic            wdtResetReq,
    output logic            wdtIrq,
    output logic            timeoutStatus
);
    import crystal_clocked_watchdog_pkg::*;

    crystal_tick_if tick ();

    logic [3:0]             prescale_reg;
    logic                   irqSel_reg;
    logic                   status_reg;
    logic                   enable_reg;
    logic                   armed_reg;
    logic [COUNT_WIDTH-1:0] count_reg;
    logic [COUNT_WIDTH-1:0] limit;
    logic [7:0]             ctrlView;
    logic [7:0]             wrData;
    logic                   ctrlWrite;
    logic                   otherWrite;
    logic                   accept;
    logic                   timedOut;
    logic                   validCode;

    crystal_tick_sampler sampler (
        .clk          (clk),
        .rst_n        (rst_n),
        .ce           (ce),
        .crystalInPin (crystalInPin),
        .tick         (tick)
    );

    // register as software sees it; unlock bit reads as the armed state
    assign ctrlView = {prescale_reg, irqSel_reg, status_reg, enable_reg, armed_reg};

    // byte write at C0H or bit write at C0H..C7H, merged into one byte
    always_comb begin
        wrData     = sfrWrData;
        ctrlWrite  = 1'b0;
        otherWrite = 1'b0;
        if (sfrWr && sfrAddr == WATCHDOG_CONTROL_ADDR) begin
            ctrlWrite = 1'b1;
        end else if (bitWr && bitAddr[7:3] == WATCHDOG_CONTROL_ADDR[7:3]) begin
            ctrlWrite = 1'b1;
            wrData    = ctrlView;
            wrData[bitAddr[2:0]] = bitVal;
        end else if (sfrWr || bitWr) begin
            otherWrite = 1'b1;
        end
    end

    // only the write that directly follows an arming write is taken
    assign accept = ctrlWrite && armed_reg;

    // timeout length in crystal periods
    assign validCode = (prescale_reg <= PRESCALE_MAX_TIMED);
    assign limit     = COUNT_WIDTH'(1) << (BASE_SHIFT + 32'(prescale_reg[2:0]));

    // timeout: count reached or immediate code selected, only while enabled
    always_comb begin
        timedOut = 1'b0;
        if (enable_reg) begin
            if (prescale_reg == PRESCALE_IMMEDIATE) begin
                timedOut = 1'b1;
            end else if (validCode && tick.tickPulse && count_reg == limit - COUNT_WIDTH'(1)) begin
                timedOut = 1'b1;
            end
        end
    end

    // unlock sequencer; any other write breaks the sequence
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            armed_reg <= 1'b0;
        end else if (ce) begin
            if (timedOut && !(irqSel_reg && prescale_reg != PRESCALE_IMMEDIATE)) begin
                armed_reg <= 1'b0;
            end else if (accept || otherWrite) begin
                armed_reg <= 1'b0;
            end else if (ctrlWrite && wrData[UNLOCK_POS]) begin
                armed_reg <= 1'b1;
            end
        end
    end

    // control fields; a watchdog reset restores defaults but keeps status
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prescale_reg <= WATCHDOG_CONTROL_RESET[PRESCALE_MSB:PRESCALE_LSB];
            irqSel_reg   <= WATCHDOG_CONTROL_RESET[IRQ_SEL_POS];
            enable_reg   <= WATCHDOG_CONTROL_RESET[ENABLE_POS];
        end else if (ce) begin
            if (timedOut && !(irqSel_reg && prescale_reg != PRESCALE_IMMEDIATE)) begin
                prescale_reg <= WATCHDOG_CONTROL_RESET[PRESCALE_MSB:PRESCALE_LSB];
                irqSel_reg   <= WATCHDOG_CONTROL_RESET[IRQ_SEL_POS];
                enable_reg   <= WATCHDOG_CONTROL_RESET[ENABLE_POS];
            end else if (accept) begin
                prescale_reg <= wrData[PRESCALE_MSB:PRESCALE_LSB];
                irqSel_reg   <= wrData[IRQ_SEL_POS];
                enable_reg   <= wrData[ENABLE_POS];
            end
        end
    end

    // status: set wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_reg <= WATCHDOG_CONTROL_RESET[STATUS_POS];
        end else if (ce) begin
            if (timedOut) begin
                status_reg <= 1'b1;
            end else if (accept && !wrData[STATUS_POS]) begin
                status_reg <= 1'b0;
            end
        end
    end

    // crystal period counter; an accepted write refreshes it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (ce) begin
            if (!enable_reg || timedOut || accept || !validCode) begin
                count_reg <= '0;
            end else if (tick.tickPulse) begin
                count_reg <= count_reg + COUNT_WIDTH'(1);
            end
        end
    end

    // action pulses; the interrupt line bypasses any global mask
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wdtResetReq <= 1'b0;
            wdtIrq      <= 1'b0;
        end else if (ce) begin
            wdtResetReq <= timedOut && !(irqSel_reg && prescale_reg != PRESCALE_IMMEDIATE);
            wdtIrq      <= timedOut && irqSel_reg && prescale_reg != PRESCALE_IMMEDIATE;
        end
    end

    // registered read data and mirrors
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sfrRdData     <= 8'h00;
            timeoutStatus <= 1'b0;
            crystalOutPin <= 1'b1;
        end else if (ce) begin
            if (sfrAddr == WATCHDOG_CONTROL_ADDR) begin
                sfrRdData <= ctrlView;
            end else begin
                sfrRdData <= 8'h00;
            end
            timeoutStatus <= status_reg;
            crystalOutPin <= ~tick.xtalLevel; // inverting drive back to the crystal
        end
    end
endmodule // crystal_clocked_watchdog

// [crystal_clocked_watchdog_assertions.sv]
// port-level assertions for the crystal clocked watchdog
// assumes the crystal stands in each phase for 8 core cycles; checks pause while ce is low
`timescale 1ns/100ps
module crystal_clocked_watchdog_assertions (
    // clock and reset
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       ce,
    // watched ports
    input wire logic [7:0] sfrAddr,
    input wire logic       sfrWr,
    input wire logic       bitWr,
    input wire logic [7:0] sfrRdData,
    input wire logic       crystalInPin,
    input wire logic       crystalOutPin,
    input wire logic       wdtResetReq,
    input wire logic       wdtIrq,
    input wire logic       timeoutStatus
);
    import crystal_clocked_watchdog_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);
    // outputs right after a hardware reset
    property p_rst; $rose(rst_n) |-> sfrRdData == 8'h00 && crystalOutPin && !timeoutStatus && !wdtIrq; endproperty
    a_rst: assert property (p_rst) else $error("outputs wrong after reset");
    // only the control address reads back
    property p_rd; sfrAddr != WATCHDOG_CONTROL_ADDR |=> sfrRdData == 8'h00; endproperty
    a_rd: assert property (p_rd) else $error("foreign address read not zero");
    // timeout actions are single pulses, never both
    property p_one_rst; wdtResetReq |=> !wdtResetReq; endproperty
    a_one_rst: assert property (p_one_rst) else $error("reset request too long");
    property p_one_irq; wdtIrq |=> !wdtIrq [*8]; endproperty
    a_one_irq: assert property (p_one_irq) else $error("interrupt repeats");
    property p_excl; !(wdtResetReq && wdtIrq); endproperty
    a_excl: assert property (p_excl) else $error("reset and interrupt together");
    // status follows each timeout and falls only after a write
    property p_set; (wdtResetReq || wdtIrq) |=> timeoutStatus; endproperty
    a_set: assert property (p_set) else $error("status not set on timeout");
    property p_clr; $fell(timeoutStatus) |-> $past(sfrWr, 2) || $past(bitWr, 2); endproperty
    a_clr: assert property (p_clr) else $error("status cleared without write");
    // crystal output drives the inverse of the settled input
    property p_xhi; crystalInPin [*8] |-> !crystalOutPin; endproperty
    a_xhi: assert property (p_xhi) else $error("crystal output not low");
    property p_xlo; !crystalInPin [*8] |-> crystalOutPin; endproperty
    a_xlo: assert property (p_xlo) else $error("crystal output not high");
endmodule // crystal_clocked_watchdog_assertions

bind crystal_clocked_watchdog crystal_clocked_watchdog_assertions chk_u (.clk, .rst_n, .ce, .sfrAddr, .sfrWr, .bitWr,
    .sfrRdData, .crystalInPin, .crystalOutPin, .wdtResetReq, .wdtIrq, .timeoutStatus);

// [crystal_clocked_watchdog_tb.sv]
// self-checking bench for the crystal clocked watchdog
// assumes the checker is bound in its own file; the crystal runs at 16 core cycles a period
`timescale 1ns/100ps
module crystal_clocked_watchdog_tb;
    import crystal_clocked_watchdog_pkg::*;
    localparam int TICK = 16;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce = 1'b1;
    logic [7:0]  sfrAddr = 8'h00;
    logic        sfrWr = 1'b0;
    logic [7:0]  sfrWrData = 8'h00;
    logic [7:0]  sfrRdData;
    logic [7:0]  bitAddr = 8'h00;
    logic        bitWr = 1'b0;
    logic        bitVal = 1'b0;
    logic        crystalInPin = 1'b0;
    logic        crystalOutPin, wdtResetReq, wdtIrq, timeoutStatus;
    logic        xtalRun = 1'b1;
    logic [15:0] lfsr = 16'h3741;
    int          fail_count = 0;
    int          compares = 0;
    int          cycles = 0;
    int          n;

    crystal_clocked_watchdog dut_u (.clk, .rst_n, .ce, .sfrAddr, .sfrWr, .sfrWrData, .sfrRdData, .bitAddr, .bitWr,
        .bitVal, .crystalInPin, .crystalOutPin, .wdtResetReq, .wdtIrq, .timeoutStatus);

    // core clock
    always #50 clk = ~clk;
    // crystal stand-in and run limit
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (xtalRun && cycles % (TICK / 2) == 0) crystalInPin <= ~crystalInPin;
        if (cycles == 90000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    function automatic logic [15:0] lfsrNext(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    // expected core cycles to a timeout for a prescale code
    function automatic int tmo(input int code);
        return (1 << (BASE_SHIFT + code)) * TICK;
    endfunction

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfrAddr <= a;
        sfrWrData <= d;
        sfrWr <= 1'b1;
        @(posedge clk);
        sfrWr <= 1'b0;
    endtask
    // bit write of the unlock bit, then a byte write
    task automatic unlockWr(input logic [7:0] d);
        @(posedge clk);
        bitAddr <= 8'hC0;
        bitVal <= 1'b1;
        bitWr <= 1'b1;
        @(posedge clk);
        bitWr <= 1'b0;
        wr(8'hC0, d);
    endtask
    task automatic rd(input logic [7:0] exp);
        @(posedge clk);
        sfrAddr <= 8'hC0;
        @(posedge clk);
        @(negedge clk);
        check(sfrRdData, exp);
    endtask
    task automatic waitPulse(input int lim);
        n = 0;
        while (wdtIrq !== 1'b1 && wdtResetReq !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic checkTime(input int code);
        check({7'h00, n > tmo(code) - 40 && n < tmo(code) + 40}, 8'h01);
    endtask
    task automatic tally_and_finish;
        if (fail_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h10);
        // writes without unlock, or after a foreign write, are dropped
        repeat (4) begin
            lfsr = lfsrNext(lfsr);
            wr(8'hC0, lfsr[7:0] & 8'hFE);
            wr(8'hC0, 8'h01); // arming write stores nothing
            wr(8'h80, lfsr[15:8]); // foreign write disarms
            wr(8'hC0, lfsr[15:8] & 8'hFE);
        end
        rd(8'h10);
        unlockWr(8'h00);
        rd(8'h00);
        waitPulse(tmo(0) + 2000);
        check({7'h00, n == tmo(0) + 2000}, 8'h01);
        // interrupt mode, code 0, refreshed once midway
        unlockWr(8'h0A);
        repeat (6000) @(posedge clk);
        unlockWr(8'h0A);
        waitPulse(20000);
        checkTime(0);
        check({7'h00, wdtIrq}, 8'h01);
        rd(8'h0E);
        check({7'h00, timeoutStatus}, 8'h01);
        // stopped crystal means no progress
        xtalRun <= 1'b0;
        waitPulse(20000);
        check({7'h00, n == 20000}, 8'h01);
        xtalRun <= 1'b1;
        unlockWr(8'h00);
        rd(8'h00);
        check({7'h00, timeoutStatus}, 8'h00);
        // reset mode, code 1, then immediate code
        unlockWr(8'h12);
        waitPulse(40000);
        checkTime(1);
        check({7'h00, wdtResetReq}, 8'h01);
        rd(8'h14);
        unlockWr(8'h82);
        waitPulse(20);
        check({7'h00, wdtResetReq}, 8'h01);
        rd(8'h14);
        // clock enable low freezes the register against writes
        ce <= 1'b0;
        unlockWr(8'h00);
        ce <= 1'b1;
        rd(8'h14);
        // hardware reset clears status
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h10);
        tally_and_finish();
    end
endmodule // crystal_clocked_watchdog_tb
